/* hdl/serial_slave_pkg.sv */
// Purpose: shared constants and types for the two-wire slave port with alert output
// Assumes: 20 MHz system clock, bus clock well below a quarter of it
// Notes: address prefixes select the sensor or the storage function
`default_nettype none
package serial_slave_pkg;
  localparam logic [3:0] SENSOR_PREFIX = 4'h9;   // 1001
  localparam logic [3:0] STORE_PREFIX = 4'hA;    // 1010
  localparam int STRAP_W = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;        // index of eighth bit in a byte
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] SYNC_RST = 2'h3;        // idle bus reads high
  localparam logic STRAP_PIN_RST = 1'b0;         // pulled-down strap level

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_END = 3'h2,
    ST_ADDR_ACK = 3'h3,
    ST_WRITE = 3'h4,
    ST_WRITE_END = 3'h5,
    ST_READ = 3'h6,
    ST_READ_ACK = 3'h7
  } link_state_t;
endpackage
`default_nettype wire

/* hdl/alert_output.sv */
// Purpose: alert pin logic with interrupt and comparator modes and polarity
// Assumes: limit flags come from logic on the same clock
// Notes: drives only an output enable; the pin is open drain
`default_nettype none
module alert_output (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // limit state and configuration
  input wire logic over_high_in,
  input wire logic under_low_in,
  input wire logic alarm_mode_select_in,
  input wire logic alert_polarity_select_in,
  input wire logic read_clear_in,
  // pin
  output logic alert_oe_out
);
  import serial_slave_pkg::*;

  typedef struct packed {
    logic limit_prev;
    logic latched;
    logic oe;
  } alert_state_t;

  alert_state_t st;
  alert_state_t next_st;
  logic beyond;
  logic active;

  // limit crossing detection and mode choice
  always_comb begin
    next_st = st;
    beyond = over_high_in | under_low_in;
    next_st.limit_prev = beyond;
    // set wins over a read clear in the same cycle
    if (beyond && !st.limit_prev) begin
      next_st.latched = 1'b1;
    end else if (read_clear_in) begin
      next_st.latched = 1'b0;
    end
    active = alarm_mode_select_in ? st.latched : beyond;
    // active-low pulls the pin; active-high releases it to the pull-up
    next_st.oe = alert_polarity_select_in ? ~active : active;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st <= '{limit_prev: 1'b0, latched: 1'b0, oe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign alert_oe_out = st.oe;
endmodule // alert_output
`default_nettype wire

/* hdl/serial_slave_pins_alert.sv */
// Purpose: two-wire serial slave port of a sensor device, with strapped address and alert pin
// Assumes: bus clock and data come from pins and are synchronised to ref_clk_in
// Notes: byte data is exchanged with the device core on plain user ports
// How it works
// - data bits are sampled at bus clock rising edges and driven only after falling edges.
// - the data line is only pulled low or released, never driven high.
// - the alert pin is asserted when the temperature is past a limit, open drain only.
// - a mode bit chooses between interrupt and comparator alert behaviour.
// - the alert is active low after reset and active high when the polarity bit is set.
// - the low three address bits come from the three strap pins.
// - a floating strap reads as zero, so straps should be tied to a fixed level.
// - the upper address nibble is 1001 for the sensor and 1010 for the storage function.
// - a matching address byte is acknowledged, a mismatch is ignored and the port idles.
`default_nettype none
module serial_slave_pins_alert (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // address straps
  input wire logic [serial_slave_pkg::STRAP_W-1:0] addr_strap_inputs_in,
  // alert pin and its configuration
  input wire logic alarm_mode_select_in,
  input wire logic alert_polarity_select_in,
  input wire logic over_high_in,
  input wire logic under_low_in,
  output logic alert_out,
  output logic alert_oe_out,
  // user side
  input wire logic [7:0] tx_data_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic tx_load_out,
  output logic addr_match_out,
  output logic store_sel_out,
  output logic read_mode_out
);
  import serial_slave_pkg::*;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [2:0] strap_a;
    logic [2:0] strap_b;
    logic scl_prev;
    logic sda_prev;
    link_state_t state;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic master_nack;
    logic sda_oe;
    logic sda_o;
    logic [7:0] rx_data;
    logic rx_valid;
    logic tx_load;
    logic match;
    logic store_sel;
    logic rd;
    logic read_clear;
    logic alert_o;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] prefix;
  logic hit_sensor;
  logic hit_store;
  logic alert_oe_int;

  // second sync stage feeds all logic; first stage is read by the second alone
  assign scl_s = st.scl_sync[1];
  assign sda_s = st.sda_sync[1];
  assign scl_rise = scl_s & ~st.scl_prev;
  assign scl_fall = ~scl_s & st.scl_prev;
  assign start_seen = scl_s & st.scl_prev & st.sda_prev & ~sda_s;
  assign stop_seen = scl_s & st.scl_prev & ~st.sda_prev & sda_s;
  // byte is {address[6:0], rw}: the fixed nibble sits in the top four bits
  assign prefix = st.shift[7:4];
  assign hit_sensor = (prefix == SENSOR_PREFIX);
  assign hit_store = (prefix == STORE_PREFIX);

  always_comb begin
    next_st = st;
    next_st.scl_sync = {st.scl_sync[0], scl_in};
    next_st.sda_sync = {st.sda_sync[0], sda_in};
    // three strap bits, two flops each before use
    next_st.strap_a = addr_strap_inputs_in;
    next_st.strap_b = st.strap_a;
    next_st.scl_prev = scl_s;
    next_st.sda_prev = sda_s;
    next_st.rx_valid = 1'b0;
    next_st.tx_load = 1'b0;
    next_st.read_clear = 1'b0;
    next_st.sda_o = 1'b0;                          // never drive high
    next_st.alert_o = 1'b0;                        // alert is open drain too
    if (stop_seen) begin
      next_st.state = ST_IDLE;
      next_st.sda_oe = 1'b0;
      next_st.match = 1'b0;
    end else if (start_seen) begin
      // repeated start restarts the address phase
      next_st.state = ST_ADDR;
      next_st.cnt = CNT_RST;
      next_st.sda_oe = 1'b0;
      next_st.match = 1'b0;
    end else begin
      case (st.state)
        ST_IDLE: begin
          next_st.sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_st.shift = {st.shift[6:0], sda_s};
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == LAST_BIT) begin
              next_st.state = ST_ADDR_END;
            end
          end
        end
        ST_ADDR_END: begin
          if (scl_fall) begin
            // compare all seven address bits, straps in the low three
            if ((hit_sensor || hit_store) && st.shift[3:1] == st.strap_b) begin
              next_st.sda_oe = 1'b1;                 // ack after falling edge
              next_st.state = ST_ADDR_ACK;
              next_st.match = 1'b1;
              next_st.store_sel = hit_store;
              next_st.rd = st.shift[0];
            end else begin
              next_st.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_st.cnt = CNT_RST;
            if (st.rd) begin
              // first read byte goes out right after the ack clock
              next_st.shift = tx_data_in;
              next_st.tx_load = 1'b1;
              next_st.read_clear = ~st.store_sel;
              next_st.sda_oe = ~tx_data_in[7];
              next_st.state = ST_READ;
            end else begin
              next_st.sda_oe = 1'b0;
              next_st.state = ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (scl_rise) begin
            next_st.shift = {st.shift[6:0], sda_s};
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == LAST_BIT) begin
              next_st.state = ST_WRITE_END;
            end
          end
        end
        ST_WRITE_END: begin
          if (scl_fall) begin
            next_st.sda_oe = 1'b1;
            next_st.rx_data = st.shift;
            next_st.rx_valid = 1'b1;
            next_st.state = ST_ADDR_ACK;
            next_st.rd = 1'b0;
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == LAST_BIT) begin
              next_st.sda_oe = 1'b0;                 // release for master ack
              next_st.state = ST_READ_ACK;
            end else begin
              next_st.shift = {st.shift[6:0], 1'b0};
              next_st.sda_oe = ~st.shift[6];
            end
          end
        end
        ST_READ_ACK: begin
          if (scl_rise) begin
            next_st.master_nack = sda_s;
          end else if (scl_fall) begin
            next_st.cnt = CNT_RST;
            if (st.master_nack) begin
              // master is done; stay off the line until stop or start
              next_st.state = ST_IDLE;
            end else begin
              next_st.shift = tx_data_in;
              next_st.tx_load = 1'b1;
              next_st.sda_oe = ~tx_data_in[7];
              next_st.state = ST_READ;
            end
          end
        end
        default: begin
          next_st.state = ST_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // single state register; reset values are constants only
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st <= '{scl_sync: SYNC_RST, sda_sync: SYNC_RST,
              strap_a: {STRAP_W{STRAP_PIN_RST}}, strap_b: {STRAP_W{STRAP_PIN_RST}},
              scl_prev: 1'b1, sda_prev: 1'b1, state: ST_IDLE, cnt: CNT_RST,
              shift: BYTE_RST, master_nack: 1'b0, sda_oe: 1'b0, sda_o: 1'b0,
              rx_data: BYTE_RST, rx_valid: 1'b0, tx_load: 1'b0, match: 1'b0,
              store_sel: 1'b0, rd: 1'b0, read_clear: 1'b0, alert_o: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // alert pin; a sensor read clears a latched interrupt
  alert_output u_alert (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .over_high_in(over_high_in),
    .under_low_in(under_low_in),
    .alarm_mode_select_in(alarm_mode_select_in),
    .alert_polarity_select_in(alert_polarity_select_in),
    .read_clear_in(st.read_clear),
    .alert_oe_out(alert_oe_int)
  );

  assign sda_out = st.sda_o;
  assign sda_oe_out = st.sda_oe;
  assign alert_out = st.alert_o;
  assign alert_oe_out = alert_oe_int;
  assign rx_data_out = st.rx_data;
  assign rx_valid_out = st.rx_valid;
  assign tx_load_out = st.tx_load;
  assign addr_match_out = st.match;
  assign store_sel_out = st.store_sel;
  assign read_mode_out = st.rd;
endmodule // serial_slave_pins_alert
`default_nettype wire

/* tb/i2c_host_model.sv */
// Purpose: bus master model for the slave port
// Assumes: 400 ns bus clock, pull-up on data
// Notes: data only pulled low, never driven high
`default_nettype none
module i2c_host_model (
  // resolved data line
  input wire logic sda_in,
  // clock and data pull-down
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus: both lines high
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // start or repeated start
  task automatic start();
    #100 sda_low_out = 1'b0;
    #100 scl_out = 1'b1;
    #100 sda_low_out = 1'b1;
    #100 scl_out = 1'b0;
  endtask
  // stop leaves the clock high
  task automatic stop();
    #100 sda_low_out = 1'b1;
    #100 scl_out = 1'b1;
    #100 sda_low_out = 0;
    #100;
  endtask
  // nine bits, data moved only while the clock is low
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #100 sda_low_out = !d[i];
      #100 scl_out = 1'b1;
      #100 q[i] = sda_in;
      #100 scl_out = 1'b0;
    end
  endtask
endmodule // i2c_host_model
`default_nettype wire

/* tb/serial_slave_pins_alert_checker.sv */
// Purpose: port checks of the slave port and alert pin
// Assumes: one clock domain
// Notes: latencies as handed over
`default_nettype none
module serial_slave_pins_alert_checker (
  // watched ports
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic alarm_mode_select_in,
  input wire logic alert_polarity_select_in,
  input wire logic over_high_in,
  input wire logic under_low_in,
  input wire logic alert_out,
  input wire logic alert_oe_out,
  input wire logic rx_valid_out,
  input wire logic tx_load_out,
  input wire logic addr_match_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // interrupt mode, active-low pin
  sequence s_int; alarm_mode_select_in && !alert_polarity_select_in; endsequence
  // a high drive would fight the pull-up
  property p_sda; sda_out == 1'b0; endproperty
  property p_alrt; alert_out == 1'b0; endproperty
  property p_cmp;
    $past(rstn_in) && !$past(alarm_mode_select_in) && $stable(alert_polarity_select_in)
      |-> alert_oe_out == ($past(over_high_in || under_low_in) ^ alert_polarity_select_in);
  endproperty
  // latch then pin register: two clocks from the crossing to the pin
  property p_set;
    s_int ##0 $rose(over_high_in || under_low_in) ##1 s_int |=> alert_oe_out;
  endproperty
  // a clear strobe one cycle back may still drop the pin
  property p_hold; s_int ##0 !tx_load_out ##1 s_int ##0 alert_oe_out |=> alert_oe_out;
  endproperty
  // answers wait for the clock to be low
  property p_late; $rose(sda_oe_out) |-> !$past(scl_in, 2); endproperty
  property p_own; $rose(sda_oe_out) |-> ##[0:4] addr_match_out; endproperty
  property p_rxack; rx_valid_out |-> ##[0:1] sda_oe_out; endproperty
  a_sda: assert property (p_sda) else $error("data pin high");
  a_alrt: assert property (p_alrt) else $error("alert pin high");
  a_cmp: assert property (p_cmp) else $error("comparator level");
  a_set: assert property (p_set) else $error("latch not set");
  a_hold: assert property (p_hold) else $error("latch lost");
  a_late: assert property (p_late) else $error("drive while clock high");
  a_own: assert property (p_own) else $error("answer unaddressed");
  a_rxack: assert property (p_rxack) else $error("byte not acked");
endmodule // serial_slave_pins_alert_checker
bind serial_slave_pins_alert serial_slave_pins_alert_checker u_chk (.*);
`default_nettype wire

/* tb/test_serial_slave_pins_alert.sv */
// Purpose: self-checking bench of the slave port and alert pin
// Assumes: straps and limit flags change at clock edges
// Notes: floating straps modelled as driven low
`default_nettype none
module test_serial_slave_pins_alert;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_slave_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, mode = 1'b0, alert_polarity_select = 1'b0, over = 1'b0, under = 1'b0;
  logic scl, host_low, sda_oe, alert_oe, match, store, rd;
  logic [2:0] strap = 3'h0;
  logic [7:0] tx_data = 8'h96, rx_data;
  logic [8:0] q;
  int n_fail = 0;
  int total_checks = 0;
  // pull-up: released means high
  wire logic sda = !(host_low || sda_oe);
  i2c_host_model u_host (.sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  serial_slave_pins_alert u_dut (.ref_clk_in(clk), .rstn_in(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .addr_strap_inputs_in(strap),
    .alarm_mode_select_in(mode), .alert_polarity_select_in(alert_polarity_select), .over_high_in(over),
    .under_low_in(under), .alert_out(), .alert_oe_out(alert_oe), .tx_data_in(tx_data),
    .rx_data_out(rx_data), .rx_valid_out(), .tx_load_out(), .addr_match_out(match),
    .store_sel_out(store), .read_mode_out(rd));
  initial forever #25 clk = !clk;
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // sample away from the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // start, address, one byte if acked, stop
  task automatic txn(input logic [7:0] a, input logic [8:0] d, input logic nak,
                     input logic [8:0] x, input logic [2:0] f);
    u_host.start();
    u_host.xfer({a, 1'b1}, q);
    chk(q, {a, nak});
    chk({6'h00, match, store, rd}, {6'h00, f});
    if (!nak) begin
      u_host.xfer(d, q);
      chk(q, x);
    end
    u_host.stop();
  endtask
  // every strap, then a neighbour address
  task automatic t_straps();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) strap <= 3'(i);
      settle(3);
      v = 8'(i) ^ 8'hA5;
      txn({SENSOR_PREFIX, 3'(i), 1'b0}, {v, 1'b1}, 1'b0, {v, 1'b0}, 3'h4);
      chk({1'b0, rx_data}, {1'b0, v});
    end
    txn({SENSOR_PREFIX, 3'h6, 1'b0}, 9'h1FF, 1'b1, 9'h000, 3'h0); // straps at 7
  endtask
  // comparator mode, both polarities
  task automatic t_cmp();
    @(posedge clk) over <= 1'b1;
    settle(1);
    chk({8'h00, alert_oe}, 9'h001);
    @(posedge clk) over <= 1'b0;
    settle(1);
    chk({8'h00, alert_oe}, 9'h000);
    @(posedge clk) alert_polarity_select <= 1'b1;
    settle(1);
    chk({8'h00, alert_oe}, 9'h001);
    @(posedge clk) under <= 1'b1;
    settle(1);
    chk({8'h00, alert_oe}, 9'h000);
    @(posedge clk) begin
      under <= 1'b0;
      alert_polarity_select <= 1'b0; // shared line kept active low
    end
  endtask
  // latch survives a storage read, a sensor read clears it
  task automatic t_int();
    @(posedge clk) mode <= 1'b1;
    settle(1);
    // a sensor read first empties the latch left from comparator tests
    txn({SENSOR_PREFIX, 3'h7, 1'b1}, 9'h1FF, 1'b0, {tx_data, 1'b1}, 3'h5);
    settle(1);
    chk({8'h00, alert_oe}, 9'h000);
    @(posedge clk) under <= 1'b1;
    @(posedge clk) under <= 1'b0;
    settle(2);
    chk({8'h00, alert_oe}, 9'h001);
    // host queries the alert response address; the port does not answer it
    txn(8'h19, 9'h1FF, 1'b1, 9'h000, 3'h1);
    chk({8'h00, alert_oe}, 9'h001);
    txn({STORE_PREFIX, 3'h7, 1'b1}, 9'h1FF, 1'b0, {tx_data, 1'b1}, 3'h7);
    chk({8'h00, alert_oe}, 9'h001);
    txn({SENSOR_PREFIX, 3'h7, 1'b1}, 9'h1FF, 1'b0, {tx_data, 1'b1}, 3'h5);
    settle(1);
    chk({8'h00, alert_oe}, 9'h000);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    settle(3);
    chk({7'h00, alert_oe, sda_oe}, 9'h000);
    t_straps();
    t_cmp();
    t_int();
    results();
  end
  // hang guard
  initial begin
    #3000000;
    n_fail++;
    results();
  end
endmodule // test_serial_slave_pins_alert
`default_nettype wire
